// >>> p2pvcr_consts.vh
// Constants for the peer-to-peer violation and completion redirect block
`ifndef P2PVCR_CONSTS_VH
`define P2PVCR_CONSTS_VH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define P2PVCR_CTRL_OFF 12'h000
`define P2PVCR_VSTAT_OFF 12'h004
`define P2PVCR_VMASK_OFF 12'h008
`define P2PVCR_VSEV_OFF 12'h00C
`define P2PVCR_ISTAT_OFF 12'h010
`define P2PVCR_IMASK_OFF 12'h014
`define P2PVCR_HDR0_OFF 12'h018
`define P2PVCR_HDR1_OFF 12'h01C
`define P2PVCR_EGV_OFF 12'h020
`define P2PVCR_CNT_OFF 12'h024
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define P2PVCR_CTRL_EGR 0
`define P2PVCR_CTRL_RRD 1
`define P2PVCR_CTRL_CRD 2
`define P2PVCR_CTRL_DTR 3
`define P2PVCR_CTRL_MFD 4
`define P2PVCR_CTRL_W 5
// ----------------------------------------------------------------
// Interrupt status bits
// ----------------------------------------------------------------
`define P2PVCR_IRQ_VIOL 0
`define P2PVCR_IRQ_FATAL 1
`define P2PVCR_IRQ_ADV 2
`define P2PVCR_IRQ_STA 3
`define P2PVCR_IRQ_W 4
// ----------------------------------------------------------------
// Violation status bits and write-one clears
// ----------------------------------------------------------------
`define P2PVCR_VSTAT_VIOL 0
`define P2PVCR_VSTAT_CLR_STAP 8
`define P2PVCR_VSTAT_CLR_STAS 9
`define P2PVCR_VSTAT_CLR_RTAP 10
`define P2PVCR_VSTAT_CLR_RTAS 11
// ----------------------------------------------------------------
// Request decisions and completion status
// ----------------------------------------------------------------
`define P2PVCR_DEC_DIRECT 2'h0
`define P2PVCR_DEC_UP 2'h1
`define P2PVCR_DEC_VIOL 2'h2
`define P2PVCR_CPL_CA 3'h4
`endif

// >>> p2pvcr_top.v
// Peer-to-peer access violation handling and completion redirect
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Local design decisions: the placing of the registers and register access over APB.
`include "p2pvcr_consts.vh"
`default_nettype none
module p2pvcr_top #(
  parameter NTGT = 8
) (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire req_valid,
  input wire req_posted,
  input wire req_translated,
  input wire req_secondary,
  input wire req_rc_reject,
  input wire req_from_rciep,
  input wire [2:0] req_target,
  input wire [63:0] req_header,
  output reg req_fwd_valid,
  output reg [1:0] req_decision,
  output reg cpl_gen_valid,
  output reg [2:0] cpl_gen_status,
  output reg cpl_by_collector,
  input wire cpl_valid,
  input wire cpl_ro,
  input wire cpl_is_read,
  output reg cpl_route_valid,
  output reg cpl_upstream,
  input wire rx_cpl_ca,
  input wire rx_cpl_secondary,
  output reg sta_primary_q,
  output reg sta_secondary_q,
  output reg rta_primary_q,
  output reg rta_secondary_q,
  output wire irq
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [`P2PVCR_CTRL_W-1:0] ctrl_q;
  reg vstat_q;
  reg vmask_q;
  reg vsev_q;
  reg [`P2PVCR_IRQ_W-1:0] istat_q;
  reg [`P2PVCR_IRQ_W-1:0] imask_q;
  reg [63:0] hdr_q;
  reg hdr_valid_q;
  reg [NTGT-1:0] egv_q;
  reg [15:0] cnt_q;
  wire wr_en;
  wire rd_en;
  reg addr_ok;
  reg [`P2PVCR_IRQ_W-1:0] ev;
  reg viol;
  reg logged;
  reg [1:0] dec;
  reg up;
  reg np_viol;
  reg [31:0] rd_word;
  wire wr_ctrl;
  wire wr_vstat;
  wire wr_vmask;
  wire wr_vsev;
  wire wr_istat;
  wire wr_imask;
  wire wr_egv;
  wire wr_cnt;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function [1:0] p2pvcr_decide;
    input e;
    input r;
    input vb;
    input tr;
    input dt;
    begin
      if (tr && dt) begin
        p2pvcr_decide = `P2PVCR_DEC_DIRECT;
      end else if (r && (!e || vb)) begin
        p2pvcr_decide = `P2PVCR_DEC_UP;
      end else if (e && !r && vb) begin
        p2pvcr_decide = `P2PVCR_DEC_VIOL;
      end else begin
        p2pvcr_decide = `P2PVCR_DEC_DIRECT;
      end
    end
  endfunction

  // Register select for a write in its access phase
  function p2pvcr_wsel;
    input en;
    input [11:0] a;
    input [11:0] off;
    begin
      p2pvcr_wsel = en && (a == off);
    end
  endfunction

  // Sticky flag: a same-cycle set beats a write-one clear
  function p2pvcr_sticky;
    input cur;
    input set;
    input clr;
    begin
      p2pvcr_sticky = set || (cur && !clr);
    end
  endfunction

  // ----------------------------------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  // Read data loaded in setup so it stands through the access phase
  assign rd_en = psel && !penable && !pwrite;
  assign irq = |(istat_q & imask_q);

  // ----------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------
  assign wr_ctrl = p2pvcr_wsel(wr_en, paddr, `P2PVCR_CTRL_OFF);
  assign wr_vstat = p2pvcr_wsel(wr_en, paddr, `P2PVCR_VSTAT_OFF);
  assign wr_vmask = p2pvcr_wsel(wr_en, paddr, `P2PVCR_VMASK_OFF);
  assign wr_vsev = p2pvcr_wsel(wr_en, paddr, `P2PVCR_VSEV_OFF);
  assign wr_istat = p2pvcr_wsel(wr_en, paddr, `P2PVCR_ISTAT_OFF);
  assign wr_imask = p2pvcr_wsel(wr_en, paddr, `P2PVCR_IMASK_OFF);
  assign wr_egv = p2pvcr_wsel(wr_en, paddr, `P2PVCR_EGV_OFF);
  assign wr_cnt = p2pvcr_wsel(wr_en, paddr, `P2PVCR_CNT_OFF);

  always @* begin
    addr_ok = (paddr <= `P2PVCR_CNT_OFF) && (paddr[1:0] == 2'h0);
  end

  always @* begin
    case (paddr)
      `P2PVCR_CTRL_OFF: rd_word = {27'h0000000, ctrl_q};
      `P2PVCR_VSTAT_OFF: rd_word = {31'h00000000, vstat_q};
      `P2PVCR_VMASK_OFF: rd_word = {31'h00000000, vmask_q};
      `P2PVCR_VSEV_OFF: rd_word = {31'h00000000, vsev_q};
      `P2PVCR_ISTAT_OFF: rd_word = {28'h0000000, istat_q};
      `P2PVCR_IMASK_OFF: rd_word = {28'h0000000, imask_q};
      `P2PVCR_HDR0_OFF: rd_word = hdr_q[31:0];
      `P2PVCR_HDR1_OFF: rd_word = hdr_q[63:32];
      `P2PVCR_EGV_OFF: rd_word = {{(32-NTGT){1'b0}}, egv_q};
      `P2PVCR_CNT_OFF: rd_word = {16'h0000, cnt_q};
      default: rd_word = 32'h00000000;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Request path
  // ----------------------------------------------------------------
  always @* begin
    dec = p2pvcr_decide(ctrl_q[`P2PVCR_CTRL_EGR], ctrl_q[`P2PVCR_CTRL_RRD],
      egv_q[req_target], req_translated, ctrl_q[`P2PVCR_CTRL_DTR]);
    viol = req_valid && (req_rc_reject || (dec == `P2PVCR_DEC_VIOL));
    logged = viol && !vmask_q;
    np_viol = viol && !req_posted;
    ev = {`P2PVCR_IRQ_W{1'b0}};
    ev[`P2PVCR_IRQ_VIOL] = logged;
    ev[`P2PVCR_IRQ_FATAL] = logged && vsev_q;
    ev[`P2PVCR_IRQ_ADV] = logged && !vsev_q && !req_posted;
    ev[`P2PVCR_IRQ_STA] = viol;
  end

  always @(posedge clk) begin
    if (rst) begin
      req_fwd_valid <= 1'b0;
      req_decision <= `P2PVCR_DEC_DIRECT;
      cpl_gen_valid <= 1'b0;
      cpl_gen_status <= 3'h0;
      cpl_by_collector <= 1'b0;
    end else begin
      // Dropped when violating; posted requests get no completion
      req_fwd_valid <= req_valid && !viol;
      req_decision <= viol ? `P2PVCR_DEC_VIOL : dec;
      cpl_gen_valid <= np_viol;
      cpl_gen_status <= np_viol ? `P2PVCR_CPL_CA : 3'h0;
      cpl_by_collector <= viol && req_rc_reject && req_from_rciep;
    end
  end

  // ----------------------------------------------------------------
  // Completion routing
  // ----------------------------------------------------------------
  always @* begin
    up = ctrl_q[`P2PVCR_CTRL_CRD] && !cpl_ro;
    if (ctrl_q[`P2PVCR_CTRL_MFD]) begin
      up = up && cpl_is_read;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      cpl_route_valid <= 1'b0;
      cpl_upstream <= 1'b0;
    end else begin
      cpl_route_valid <= cpl_valid;
      cpl_upstream <= cpl_valid && up;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      ctrl_q <= {`P2PVCR_CTRL_W{1'b0}};
      vmask_q <= 1'b0;
      vsev_q <= 1'b0;
      imask_q <= {`P2PVCR_IRQ_W{1'b0}};
      egv_q <= {NTGT{1'b0}};
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[`P2PVCR_CTRL_W-1:0];
      end
      if (wr_vmask) begin
        vmask_q <= pwdata[0];
      end
      if (wr_vsev) begin
        vsev_q <= pwdata[0];
      end
      if (wr_imask) begin
        imask_q <= pwdata[`P2PVCR_IRQ_W-1:0];
      end
      if (wr_egv) begin
        egv_q <= pwdata[NTGT-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Violation status and interrupt sources
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      vstat_q <= 1'b0;
      istat_q <= {`P2PVCR_IRQ_W{1'b0}};
    end else begin
      // Status stays sticky even when logging is masked
      vstat_q <= p2pvcr_sticky(vstat_q, viol,
        wr_vstat && pwdata[`P2PVCR_VSTAT_VIOL]);
      if (wr_istat) begin
        istat_q <= (istat_q & ~pwdata[`P2PVCR_IRQ_W-1:0]) | ev;
      end else begin
        istat_q <= istat_q | ev;
      end
    end
  end

  // ----------------------------------------------------------------
  // Offending header capture
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      hdr_q <= 64'h0000000000000000;
      hdr_valid_q <= 1'b0;
    end else begin
      // First offending header kept until status is cleared
      if (logged && !hdr_valid_q) begin
        hdr_q <= req_header;
        hdr_valid_q <= 1'b1;
      end else if (!vstat_q) begin
        hdr_valid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Logged violation counter
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 16'h0000;
    end else begin
      // Saturates so a flood never wraps to a small count
      if (logged && cnt_q != 16'hFFFF) begin
        cnt_q <= cnt_q + 16'h0001;
      end else if (wr_cnt) begin
        cnt_q <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Target abort flags
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      sta_primary_q <= 1'b0;
      sta_secondary_q <= 1'b0;
      rta_primary_q <= 1'b0;
      rta_secondary_q <= 1'b0;
    end else begin
      sta_primary_q <= p2pvcr_sticky(sta_primary_q, viol && !req_secondary,
        wr_vstat && pwdata[`P2PVCR_VSTAT_CLR_STAP]);
      sta_secondary_q <= p2pvcr_sticky(sta_secondary_q, viol && req_secondary,
        wr_vstat && pwdata[`P2PVCR_VSTAT_CLR_STAS]);
      // Same function may act as requester of its own aborted request
      rta_primary_q <= p2pvcr_sticky(rta_primary_q, rx_cpl_ca && !rx_cpl_secondary,
        wr_vstat && pwdata[`P2PVCR_VSTAT_CLR_RTAP]);
      rta_secondary_q <= p2pvcr_sticky(rta_secondary_q, rx_cpl_ca && rx_cpl_secondary,
        wr_vstat && pwdata[`P2PVCR_VSTAT_CLR_RTAS]);
    end
  end
endmodule
`default_nettype wire

// >>> p2pvcr_peer.sv
// Requester model that receives the block's abort completions
`default_nettype none
module p2pvcr_peer (
  input wire logic clk,
  input wire logic on_sec,
  input wire logic cpl_gen_valid,
  input wire logic [2:0] cpl_gen_status,
  output logic rx_cpl_ca,
  output logic rx_cpl_secondary
);
  timeunit 1ns;
  timeprecision 1ns;
  // Abort answer comes back one cycle later, on the side it left from
  always @(posedge clk) begin
    rx_cpl_ca <= cpl_gen_valid && cpl_gen_status == 3'h4;
    rx_cpl_secondary <= on_sec;
  end
endmodule
`default_nettype wire

// >>> p2pvcr_sva.sv
// Assertion checker for the peer violation block
`default_nettype none
module p2pvcr_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic req_valid,
  input wire logic req_posted,
  input wire logic req_secondary,
  input wire logic req_rc_reject,
  input wire logic req_from_rciep,
  input wire logic req_fwd_valid,
  input wire logic cpl_gen_valid,
  input wire logic [2:0] cpl_gen_status,
  input wire logic cpl_by_collector,
  input wire logic cpl_valid,
  input wire logic cpl_ro,
  input wire logic cpl_route_valid,
  input wire logic cpl_upstream,
  input wire logic sta_secondary_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rej_np; req_valid && !req_posted && req_rc_reject; endsequence
  sequence s_ca; cpl_gen_valid && cpl_gen_status == 3'h4; endsequence
  a_np_abort: assert property (s_rej_np |=> s_ca)
    else $error("no abort completion");
  a_gen_cause: assert property (
    cpl_gen_valid |-> $past(req_valid) && !$past(req_posted))
    else $error("completion without request");
  a_posted_drop: assert property (
    req_valid && req_posted && req_rc_reject |=> !cpl_gen_valid && !req_fwd_valid)
    else $error("posted violation answered");
  a_sta_sec: assert property (
    req_valid && req_rc_reject && req_secondary |=> sta_secondary_q)
    else $error("target abort not set");
  a_sta_hold: assert property (sta_secondary_q && !psel |=> sta_secondary_q)
    else $error("target abort lost");
  a_collector: assert property (
    s_rej_np ##0 req_from_rciep |=> s_ca and cpl_by_collector)
    else $error("collector not completer");
  a_ro_direct: assert property (cpl_valid && cpl_ro |=> cpl_route_valid && !cpl_upstream)
    else $error("relaxed completion redirected");
  a_route_cause: assert property (cpl_route_valid |-> $past(cpl_valid))
    else $error("route without completion");
endmodule
bind p2pvcr_top p2pvcr_sva u_sva (.clk(clk), .rst(rst), .psel(psel), .req_valid(req_valid),
  .req_posted(req_posted), .req_secondary(req_secondary), .req_rc_reject(req_rc_reject),
  .req_from_rciep(req_from_rciep), .req_fwd_valid(req_fwd_valid),
  .cpl_gen_valid(cpl_gen_valid), .cpl_gen_status(cpl_gen_status),
  .cpl_by_collector(cpl_by_collector), .cpl_valid(cpl_valid), .cpl_ro(cpl_ro),
  .cpl_route_valid(cpl_route_valid), .cpl_upstream(cpl_upstream),
  .sta_secondary_q(sta_secondary_q));
`default_nettype wire

// >>> p2p_violation_completion_redirect_test.sv
// Self-checking bench for the peer violation block
`include "p2pvcr_consts.vh"
`default_nettype none
module p2p_violation_completion_redirect_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic rqv = 0, rp = 0, rt = 0, rs = 0, rj = 0, ri = 0, cv = 0, cro = 0, crd = 0;
  logic [63:0] rh = 64'h1234_5678_9ABC_DEF0;
  wire [31:0] prdata;
  wire [1:0] dec;
  wire [2:0] gs;
  wire pready, pslverr, fwd, gv, gcol, rtv, rup, rxca, rxsec, stap, stas, rtap, rtas, irq;
  int fails = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  p2pvcr_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid(rqv), .req_posted(rp), .req_translated(rt), .req_secondary(rs),
    .req_rc_reject(rj), .req_from_rciep(ri), .req_target(3'h3), .req_header(rh),
    .req_fwd_valid(fwd), .req_decision(dec), .cpl_gen_valid(gv), .cpl_gen_status(gs),
    .cpl_by_collector(gcol), .cpl_valid(cv), .cpl_ro(cro), .cpl_is_read(crd),
    .cpl_route_valid(rtv), .cpl_upstream(rup), .rx_cpl_ca(rxca), .rx_cpl_secondary(rxsec),
    .sta_primary_q(stap), .sta_secondary_q(stas), .rta_primary_q(rtap),
    .rta_secondary_q(rtas), .irq(irq));
  p2pvcr_peer peer (.clk(clk), .on_sec(rs), .cpl_gen_valid(gv), .cpl_gen_status(gs),
    .rx_cpl_ca(rxca), .rx_cpl_secondary(rxsec));
  task close_out;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      close_out();
    end
    chk(pslverr, err);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, e);
  endtask
  task req(input logic p, input logic j, input logic s);
    @(posedge clk);
    rqv <= 1'b1;
    rp <= p;
    rj <= j;
    rs <= s;
    @(posedge clk);
    rqv <= 1'b0;
    @(posedge clk);
  endtask
  task t_regs;
    rdc(`P2PVCR_VSTAT_OFF, 32'h0);
    wr(`P2PVCR_CTRL_OFF, 32'h17);
    rdc(`P2PVCR_CTRL_OFF, 32'h17);
    apb(1'b0, 12'h028, 32'h0, 1'b1);
    chk(rd, 32'h0);
    $display("t_regs done");
  endtask
  task t_table;
    logic v;
    for (int i = 0; i < 8; i++) begin
      wr(`P2PVCR_EGV_OFF, {28'h0, i[2], 3'h0});
      wr(`P2PVCR_CTRL_OFF, {30'h0, i[1], i[0]});
      req(1'b0, 1'b0, 1'b0);
      v = i[0] & !i[1] & i[2];
      chk(dec, v ? 2'h2 : (i[1] & (!i[0] | i[2])) ? 2'h1 : 2'h0);
      chk({gv, gs, fwd}, v ? 5'h18 : 5'h01);
    end
    rdc(`P2PVCR_VSTAT_OFF, 32'h1);
    rdc(`P2PVCR_ISTAT_OFF, 32'hD);
    chk(stap, 1'b1);
    rdc(`P2PVCR_HDR0_OFF, 32'h9ABC_DEF0);
    rdc(`P2PVCR_HDR1_OFF, 32'h1234_5678);
    rdc(`P2PVCR_CNT_OFF, 32'h1);
    $display("t_table done");
  endtask
  task t_log;
    chk(irq, 1'b0);
    wr(`P2PVCR_IMASK_OFF, 32'h1);
    chk(irq, 1'b1);
    wr(`P2PVCR_ISTAT_OFF, 32'hF);
    chk(irq, 1'b0);
    wr(`P2PVCR_CTRL_OFF, 32'h1);
    wr(`P2PVCR_VSEV_OFF, 32'h1);
    req(1'b1, 1'b0, 1'b1);
    chk({gv, fwd, stas}, 3'h1);
    rdc(`P2PVCR_ISTAT_OFF, 32'hB);
    wr(`P2PVCR_ISTAT_OFF, 32'hF);
    wr(`P2PVCR_VMASK_OFF, 32'h1);
    req(1'b0, 1'b0, 1'b0);
    chk(gv, 1'b1);
    rdc(`P2PVCR_ISTAT_OFF, 32'h8);
    $display("t_log done");
  endtask
  task t_rc;
    wr(`P2PVCR_CTRL_OFF, 32'h2);
    wr(`P2PVCR_VSTAT_OFF, 32'hF00);
    ri <= 1'b1;
    req(1'b0, 1'b1, 1'b1);
    chk({gcol, gs, dec}, 6'h32);
    repeat (2) @(posedge clk);
    chk({rtas, rtap}, 2'h2);
    ri <= 1'b0;
    wr(`P2PVCR_CTRL_OFF, 32'h9);
    rt <= 1'b1;
    req(1'b0, 1'b0, 1'b0);
    chk({fwd, dec}, 3'h4);
    rt <= 1'b0;
    $display("t_rc done");
  endtask
  task t_cpl;
    for (int i = 0; i < 16; i++) begin
      wr(`P2PVCR_CTRL_OFF, {27'h0, i[1], 1'b0, i[0], 2'h2});
      @(posedge clk);
      cv <= 1'b1;
      cro <= i[2];
      crd <= i[3];
      @(posedge clk);
      cv <= 1'b0;
      @(posedge clk);
      chk({rtv, rup}, {1'b1, i[0] & !i[2] & (i[3] | !i[1])});
    end
    $display("t_cpl done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_table();
    t_log();
    t_rc();
    t_cpl();
    close_out();
  end
endmodule
`default_nettype wire
